/* uic_top.sv */
// Purpose: Four universal input channels with interrupt, digital, counter,
//          frequency and period-duration functions behind a plain register port.
// Assumes: 20 MHz sys_clk, synchronous active-low reset, inputs asynchronous.
// Notes:   Unsupported function codes on a channel fall back to digital input.
//
// What this block does
// - four independent channels, function chosen per channel
// - channels one, two: interrupt, digital, counter
// - channel three adds frequency and period
// - channel four: interrupt and digital only
// - interrupt mode flags the configured edge
// - digital level only given on read
// - counter counts pulses up or down
// - period mode counts ticks between equal edges
// - rising edge to rising edge, 24-bit range
// - gate selectable as 0, 1 s, 10 s
`default_nettype none

package uic_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFF   = 8'h00;
  localparam logic [7:0] CFG_OFF    = 8'h04;
  localparam logic [7:0] LEVEL_OFF  = 8'h08;
  localparam logic [7:0] STAT_OFF   = 8'h0c;
  localparam logic [7:0] MASK_OFF   = 8'h10;
  localparam logic [7:0] CNT0_OFF   = 8'h14;
  localparam logic [7:0] CNT1_OFF   = 8'h18;
  localparam logic [7:0] CNT2_OFF   = 8'h1c;
  localparam logic [7:0] FREQ_OFF   = 8'h20;
  localparam logic [7:0] PER_OFF    = 8'h24;
  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int MODE_W     = 4;
  localparam int EDGE_BIT   = 3;
  localparam int GATE_LSB   = 4;
  localparam int FREQ_IRQ   = 4;
  localparam int PER_IRQ    = 5;
  localparam int NCH        = 4;
  localparam int NCNT       = 3;
  localparam int PER_CH     = 2;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [7:0]  CFG_RST  = 8'h00;
  localparam logic [5:0]  MASK_RST = 6'h00;
  localparam logic [23:0] CNT24_MAX = 24'hffffff;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ    = 20000;
  localparam int CLK_NS     = 50;
  localparam int TICK_NS    = 500;
  localparam int TICK_CYC   = TICK_NS / CLK_NS;
  localparam int GATE_1S_MS = 1000;
  localparam int GATE_1S_CYC = GATE_1S_MS * CLK_KHZ;
  localparam int GATE_LONG_MUL = 10;
  localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);

  typedef enum logic [2:0] {
    UIC_DIGITAL = 3'b000,
    UIC_IRQ     = 3'b001,
    UIC_COUNT   = 3'b010,
    UIC_FREQ    = 3'b011,
    UIC_PERIOD  = 3'b100
  } uic_mode_t;

  typedef enum logic [1:0] {
    UIC_GATE_0   = 2'b00,
    UIC_GATE_1S  = 2'b01,
    UIC_GATE_10S = 2'b10
  } uic_gate_t;
endpackage

module uic_top #(
  parameter int GATE_1S_CYC = uic_pkg::GATE_1S_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             irq,
  input  wire logic        universal_in_one,
  input  wire logic        universal_in_two,
  input  wire logic        universal_in_three,
  input  wire logic        universal_in_four
);

  typedef struct packed {
    logic [3:0]        sync1;
    logic [3:0]        sync2;
    logic [3:0]        prev;
    logic [15:0]       mode;
    logic [7:0]        cfg;
    logic [5:0]        status;
    logic [5:0]        mask;
    logic [2:0][15:0]  cnt;
    logic [3:0]        tick;
    logic [23:0]       per_cnt;
    logic              per_run;
    logic [23:0]       per_res;
    logic [27:0]       gate_cnt;
    logic [23:0]       frq_cnt;
    logic [23:0]       frq_res;
    logic [31:0]       rdata;
    logic              irq;
  } uic_state_t;

  uic_state_t st;
  uic_state_t next_st;

  logic [3:0]       pin;
  logic [3:0]       rise;
  logic [3:0]       fall;
  uic_pkg::uic_mode_t eff [4];
  logic [27:0]      gate_len;
  uic_pkg::uic_gate_t gate_sel;

  assign pin = {universal_in_four, universal_in_three, universal_in_two, universal_in_one};
  assign gate_sel = uic_pkg::uic_gate_t'(st.cfg[uic_pkg::GATE_LSB +: 2]);
  assign gate_len = (gate_sel == uic_pkg::UIC_GATE_10S)
                  ? 28'(GATE_1S_CYC * uic_pkg::GATE_LONG_MUL) : 28'(GATE_1S_CYC);

  // ----------------------------------------------------------------
  // Per-channel edge detect and allowed functions
  // ----------------------------------------------------------------
  for (genvar c = 0; c < uic_pkg::NCH; c++) begin : g_ch
    logic [2:0] req;
    assign req     = st.mode[c*uic_pkg::MODE_W +: 3];
    assign rise[c] = st.sync2[c] & ~st.prev[c];
    assign fall[c] = ~st.sync2[c] & st.prev[c];
    always_comb begin
      eff[c] = uic_pkg::UIC_DIGITAL;
      case (req)
        uic_pkg::UIC_IRQ: begin
          eff[c] = uic_pkg::UIC_IRQ;
        end
        uic_pkg::UIC_COUNT: begin
          if (c < uic_pkg::NCNT) eff[c] = uic_pkg::UIC_COUNT;
        end
        uic_pkg::UIC_FREQ: begin
          if (c == uic_pkg::PER_CH) eff[c] = uic_pkg::UIC_FREQ;
        end
        uic_pkg::UIC_PERIOD: begin
          if (c == uic_pkg::PER_CH) eff[c] = uic_pkg::UIC_PERIOD;
        end
        default: begin
          eff[c] = uic_pkg::UIC_DIGITAL;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] ev;
    logic       tick_hit;
    ev = 6'h00;
    tick_hit = (st.tick == uic_pkg::TICK_LAST);
    next_st = st;
    next_st.sync1 = pin;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    next_st.tick  = tick_hit ? 4'h0 : st.tick + 4'h1;
    // Interrupt edges
    for (int c = 0; c < uic_pkg::NCH; c++) begin
      if (eff[c] == uic_pkg::UIC_IRQ) begin
        ev[c] = st.mode[c*uic_pkg::MODE_W + uic_pkg::EDGE_BIT] ? rise[c] : fall[c];
      end
    end
    // Pulse counters
    for (int c = 0; c < uic_pkg::NCNT; c++) begin
      if (eff[c] == uic_pkg::UIC_COUNT && rise[c]) begin
        next_st.cnt[c] = st.cfg[c] ? st.cnt[c] - 16'h0001 : st.cnt[c] + 16'h0001;
      end
    end
    // Period duration on channel three
    if (eff[uic_pkg::PER_CH] == uic_pkg::UIC_PERIOD) begin
      if (rise[uic_pkg::PER_CH]) begin
        if (st.per_run) begin
          next_st.per_res = st.per_cnt;
          ev[uic_pkg::PER_IRQ] = 1'b1;
        end
        next_st.per_run = 1'b1;
        next_st.per_cnt = 24'h000000;
      end else if (st.per_run && tick_hit && st.per_cnt != uic_pkg::CNT24_MAX) begin
        next_st.per_cnt = st.per_cnt + 24'h000001;
      end
    end else begin
      next_st.per_run = 1'b0;
      next_st.per_cnt = 24'h000000;
    end
    // Frequency gate on channel three
    if (eff[uic_pkg::PER_CH] == uic_pkg::UIC_FREQ && gate_sel != uic_pkg::UIC_GATE_0
        && gate_sel != 2'b11) begin
      if (st.gate_cnt >= gate_len - 28'h1) begin
        next_st.gate_cnt = 28'h0;
        next_st.frq_res  = st.frq_cnt + {23'h0, rise[uic_pkg::PER_CH]};
        next_st.frq_cnt  = 24'h000000;
        ev[uic_pkg::FREQ_IRQ] = 1'b1;
      end else begin
        next_st.gate_cnt = st.gate_cnt + 28'h1;
        if (rise[uic_pkg::PER_CH] && st.frq_cnt != uic_pkg::CNT24_MAX) begin
          next_st.frq_cnt = st.frq_cnt + 24'h000001;
        end
      end
    end else begin
      next_st.gate_cnt = 28'h0;
      next_st.frq_cnt  = 24'h000000;
      next_st.frq_res  = 24'h000000;
    end
    // Register writes; hardware set wins over clear
    if (wr) begin
      case (addr)
        uic_pkg::MODE_OFF: next_st.mode = wdata[15:0];
        uic_pkg::CFG_OFF:  next_st.cfg  = wdata[7:0];
        uic_pkg::STAT_OFF: next_st.status = st.status & ~wdata[5:0];
        uic_pkg::MASK_OFF: next_st.mask = wdata[5:0];
        uic_pkg::CNT0_OFF: next_st.cnt[0] = wdata[15:0];
        uic_pkg::CNT1_OFF: next_st.cnt[1] = wdata[15:0];
        uic_pkg::CNT2_OFF: next_st.cnt[2] = wdata[15:0];
        default: ;
      endcase
    end
    next_st.status = next_st.status | ev;
    next_st.irq = |(next_st.status & next_st.mask);
    // Read data valid only in the cycle after the strobe
    next_st.rdata = 32'h00000000;
    if (rd) begin
      case (addr)
        uic_pkg::MODE_OFF:  next_st.rdata = {16'h0000, st.mode};
        uic_pkg::CFG_OFF:   next_st.rdata = {24'h000000, st.cfg};
        uic_pkg::LEVEL_OFF: next_st.rdata = {28'h0000000, st.sync2};
        uic_pkg::STAT_OFF:  next_st.rdata = {26'h0000000, st.status};
        uic_pkg::MASK_OFF:  next_st.rdata = {26'h0000000, st.mask};
        uic_pkg::CNT0_OFF:  next_st.rdata = {16'h0000, st.cnt[0]};
        uic_pkg::CNT1_OFF:  next_st.rdata = {16'h0000, st.cnt[1]};
        uic_pkg::CNT2_OFF:  next_st.rdata = {16'h0000, st.cnt[2]};
        uic_pkg::FREQ_OFF:  next_st.rdata = {8'h00, st.frq_res};
        uic_pkg::PER_OFF:   next_st.rdata = {8'h00, st.per_res};
        default:            next_st.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st      <= '0;
      st.mode <= uic_pkg::MODE_RST;
      st.cfg  <= uic_pkg::CFG_RST;
      st.mask <= uic_pkg::MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq   = st.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_irq_edge;
    @(posedge sys_clk) disable iff (!resetn)
      (eff[0] == uic_pkg::UIC_IRQ && st.mode[uic_pkg::EDGE_BIT] && rise[0])
      |=> st.status[0];
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("edge did not flag");

  property p_level_read;
    @(posedge sys_clk) disable iff (!resetn)
      (rd && addr == uic_pkg::LEVEL_OFF) |=> (rdata[3:0] == $past(st.sync2));
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read wrong");

  property p_count_up;
    @(posedge sys_clk) disable iff (!resetn)
      (eff[0] == uic_pkg::UIC_COUNT && !st.cfg[0] && rise[0] && !wr)
      |=> (st.cnt[0] == $past(st.cnt[0]) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("up count wrong");

  property p_ch1_no_freq;
    @(posedge sys_clk) disable iff (!resetn)
      (st.mode[2:0] == uic_pkg::UIC_FREQ) |-> (eff[0] == uic_pkg::UIC_DIGITAL);
  endproperty
  a_ch1_no_freq: assert property (p_ch1_no_freq) else $error("ch1 freq allowed");

  property p_ch4_no_count;
    @(posedge sys_clk) disable iff (!resetn)
      (st.mode[14:12] == uic_pkg::UIC_COUNT) |-> (eff[3] == uic_pkg::UIC_DIGITAL);
  endproperty
  a_ch4_no_count: assert property (p_ch4_no_count) else $error("ch4 counts");

  property p_per_start;
    @(posedge sys_clk) disable iff (!resetn)
      (eff[2] == uic_pkg::UIC_PERIOD && rise[2] && !st.per_run)
      |=> (st.per_run && st.per_cnt == 24'h000000);
  endproperty
  a_per_start: assert property (p_per_start) else $error("period start wrong");

  property p_per_result;
    @(posedge sys_clk) disable iff (!resetn)
      (eff[2] == uic_pkg::UIC_PERIOD && rise[2] && st.per_run)
      |=> (st.per_res == $past(st.per_cnt) && st.status[uic_pkg::PER_IRQ]);
  endproperty
  a_per_result: assert property (p_per_result) else $error("period result wrong");

  property p_gate_zero;
    @(posedge sys_clk) disable iff (!resetn)
      (gate_sel == uic_pkg::UIC_GATE_0 && !wr) |=> (st.frq_res == 24'h000000);
  endproperty
  a_gate_zero: assert property (p_gate_zero) else $error("zero gate measured");

  property p_edge_once;
    @(posedge sys_clk) disable iff (!resetn)
      rise[0] |=> !rise[0];
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge seen twice");

  c_irq:   cover property (@(posedge sys_clk) disable iff (!resetn) irq);
  c_per:   cover property (@(posedge sys_clk) disable iff (!resetn)
                           st.status[uic_pkg::PER_IRQ]);
  c_count: cover property (@(posedge sys_clk) disable iff (!resetn)
                           eff[1] == uic_pkg::UIC_COUNT && rise[1]);
  c_freq:  cover property (@(posedge sys_clk) disable iff (!resetn)
                           st.status[uic_pkg::FREQ_IRQ]);

endmodule

`default_nettype wire

/* uic_sensor.sv */
// Purpose: Process-side sensor model driving pulses on the four inputs.
// Assumes: Levels change by non-blocking assignment right after a rising edge.
// Notes:   Pulse rate kept at or below 10 kHz in use.
`default_nettype none

module uic_sensor (
  input  wire logic       sys_clk,
  output logic      [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pins = 4'h0;

  task automatic set(input logic [3:0] v);
    @(posedge sys_clk);
    pins <= v;
  endtask

  // Whole pulses, high and low for half cycles each
  task automatic pulse(input logic [3:0] m, input int n, input int half);
    repeat (n) begin
      set(m);
      repeat (half - 1) @(posedge sys_clk);
      set(4'h0);
      repeat (half - 1) @(posedge sys_clk);
    end
  endtask
endmodule

`default_nettype wire

/* universal_input_counter_tb.sv */
// Purpose: Self-checking bench for the four universal input channels.
// Assumes: Gate shortened to 10000 cycles; pulses 2000 cycles apart.
// Notes:   Tick is 10 cycles, so 2000 cycles give about 200 ticks.
`default_nettype none

module universal_input_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {logic [7:0] a; logic [31:0] e;} uic_row_t;

  logic        sys_clk;
  logic        resetn;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] v;
  wire logic [31:0] rdata;
  wire logic        irq;
  wire logic [3:0]  pins;
  int          err_count;
  int          cmp_count;
  int          cyc;
  uic_row_t    rows [9];

  uic_top #(.GATE_1S_CYC(10000)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .universal_in_one(pins[0]), .universal_in_two(pins[1]),
    .universal_in_three(pins[2]), .universal_in_four(pins[3])
  );

  uic_sensor sen (.sys_clk(sys_clk), .pins(pins));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic range(input string nm, input int lo, input int hi, input logic [31:0] g);
    cmp_count++;
    if ($isunknown(g) || g < lo || g > hi) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd_reg(a, d);
    check(nm, e, d);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 70000) begin
      err_count++;
      $display("CHECK FAILED timeout expected done seen hang");
      final_report();
    end
  end

  initial begin
    resetn = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0;
    rows = '{'{uic_pkg::MODE_OFF, 32'h0}, '{uic_pkg::CFG_OFF, 32'h0},
             '{uic_pkg::MASK_OFF, 32'h0}, '{uic_pkg::STAT_OFF, 32'h0},
             '{uic_pkg::CNT0_OFF, 32'h0}, '{uic_pkg::CNT1_OFF, 32'h0},
             '{uic_pkg::CNT2_OFF, 32'h0}, '{uic_pkg::PER_OFF, 32'h0}, '{8'h40, 32'h0}};
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    // ----------------------------------------------------------------
    // Reset values and unmapped read
    // ----------------------------------------------------------------
    foreach (rows[i]) rchk("reset row", rows[i].a, rows[i].e);
    check("irq reset", 32'h0, 32'(irq));
    // ----------------------------------------------------------------
    // Counters up and down, channel four refuses counting
    // ----------------------------------------------------------------
    wr_reg(uic_pkg::MODE_OFF, 32'h2222);
    wr_reg(uic_pkg::CFG_OFF, 32'h2);
    wr_reg(uic_pkg::MASK_OFF, 32'h3f);
    sen.pulse(4'hf, 3, 1000);
    rchk("cnt one", uic_pkg::CNT0_OFF, 32'h3);
    rchk("cnt two", uic_pkg::CNT1_OFF, 32'hfffd);
    rchk("cnt three", uic_pkg::CNT2_OFF, 32'h3);
    rchk("status count", uic_pkg::STAT_OFF, 32'h0);
    wr_reg(uic_pkg::CNT0_OFF, 32'hffff);
    sen.pulse(4'h1, 1, 1000);
    rchk("cnt wrap", uic_pkg::CNT0_OFF, 32'h0);
    sen.set(4'ha);
    repeat (4) @(posedge sys_clk);
    rchk("level", uic_pkg::LEVEL_OFF, 32'ha);
    check("irq digital", 32'h0, 32'(irq));
    sen.set(4'h0);
    // ----------------------------------------------------------------
    // Interrupts on chosen edges, mask and clear
    // ----------------------------------------------------------------
    wr_reg(uic_pkg::MODE_OFF, 32'h9019);
    repeat (4) @(posedge sys_clk);
    wr_reg(uic_pkg::STAT_OFF, 32'h3f);
    sen.set(4'hb);
    repeat (6) @(posedge sys_clk);
    rchk("status rise", uic_pkg::STAT_OFF, 32'h9);
    check("irq set", 32'h1, 32'(irq));
    sen.set(4'h0);
    repeat (6) @(posedge sys_clk);
    rchk("status fall", uic_pkg::STAT_OFF, 32'hb);
    wr_reg(uic_pkg::MASK_OFF, 32'h0);
    #1 check("irq masked", 32'h0, 32'(irq));
    wr_reg(uic_pkg::STAT_OFF, 32'hb);
    rchk("status clear", uic_pkg::STAT_OFF, 32'h0);
    // ----------------------------------------------------------------
    // Period and frequency on channel three
    // ----------------------------------------------------------------
    wr_reg(uic_pkg::MASK_OFF, 32'h3f);
    wr_reg(uic_pkg::MODE_OFF, 32'h0400);
    sen.pulse(4'h4, 3, 1000);
    rd_reg(uic_pkg::PER_OFF, v);
    range("period", 199, 201, v);
    rchk("status period", uic_pkg::STAT_OFF, 32'h20);
    check("irq period", 32'h1, 32'(irq));
    wr_reg(uic_pkg::STAT_OFF, 32'h3f);
    wr_reg(uic_pkg::MODE_OFF, 32'h0300);
    wr_reg(uic_pkg::CFG_OFF, 32'h10);
    sen.pulse(4'h4, 12, 1000);
    rd_reg(uic_pkg::FREQ_OFF, v);
    range("freq", 4, 6, v);
    rchk("status freq", uic_pkg::STAT_OFF, 32'h10);
    wr_reg(uic_pkg::CFG_OFF, 32'h0);
    repeat (4) @(posedge sys_clk);
    rchk("freq gate0", uic_pkg::FREQ_OFF, 32'h0);
    // Long gate must not close where the short one would
    wr_reg(uic_pkg::STAT_OFF, 32'h3f);
    wr_reg(uic_pkg::CFG_OFF, 32'h20);
    sen.pulse(4'h4, 6, 1000);
    rchk("status gate10", uic_pkg::STAT_OFF, 32'h0);
    rchk("freq gate10", uic_pkg::FREQ_OFF, 32'h0);
    final_report();
  end
endmodule

`default_nettype wire
